/* filter_pkg.sv */
// Constants, types and helper functions for the receive address and wake filter
`default_nettype none
package filter_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MODE      = 8'h00;
  localparam logic [7:0] OFF_STA_LO    = 8'h04;
  localparam logic [7:0] OFF_STA_HI    = 8'h08;
  localparam logic [7:0] OFF_HASH_LO   = 8'h0c;
  localparam logic [7:0] OFF_HASH_HI   = 8'h10;
  localparam logic [7:0] OFF_WAKE_CSR  = 8'h14;
  localparam logic [7:0] OFF_WAKE_PORT = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1c;
  localparam int MODE_HPF       = 0;
  localparam int MODE_HASH_ONLY = 1;
  localparam int MODE_INV       = 2;
  localparam int MODE_PROMISC   = 3;
  localparam int MODE_MC_PASS   = 4;
  localparam int WK_EN      = 0;
  localparam int WK_RCV     = 1;
  localparam int WK_IRQEN   = 2;
  localparam int WK_PMEEN   = 3;
  localparam int WK_SLEEP   = 4;
  localparam int CMD_EN     = 0;
  localparam int CMD_MCAST  = 3;
  localparam int NUM_FILTERS = 4;
  localparam int PORT_WORDS  = 8;
  localparam logic [10:0] DA_LAST   = 11'h005;
  localparam logic [10:0] MASK_SPAN = 11'h01f;
  localparam logic [10:0] IDX_MAX   = 11'h7ff;
  localparam logic [31:0] CRC32_INIT = 32'hffffffff;
  localparam logic [31:0] CRC32_POLY = 32'hedb88320;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  localparam logic [15:0] CRC16_POLY = 16'ha001;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [30:0] mask;
    logic [7:0]  offset;
    logic [3:0]  cmd;
    logic [15:0] crcRef;
  } filter_cfg_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_ADDR = 3'h2,
    PH_BODY = 3'h4
  } rx_phase_type;

  function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC32_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

/* wake_crc_unit.sv */
// CRC-16 accumulator over the masked pattern bytes of one wake filter
`timescale 1ns/1ps
`default_nettype none
module wake_crc_unit (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     byteValid,
  input  wire logic                     frameStart,
  input  wire logic [10:0]              byteIdx,
  input  wire logic [7:0]               byteData,
  input  wire filter_pkg::filter_cfg_type cfg,
  output logic      [15:0]              crcNow
);
  logic [15:0] crc_q;
  wire  [10:0] relIdx = byteIdx - {3'h0, cfg.offset};
  wire         inWin  = (byteIdx >= {3'h0, cfg.offset}) && (relIdx < filter_pkg::MASK_SPAN);
  wire         take   = byteValid && inWin && cfg.mask[relIdx[4:0]];
  wire  [15:0] base   = frameStart ? filter_pkg::CRC16_INIT : crc_q;

  assign crcNow = take ? filter_pkg::crc16_byte(base, byteData) : base;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      crc_q <= filter_pkg::CRC16_INIT;
    end else if (byteValid) begin
      crc_q <= crcNow;
    end
  end
endmodule
`default_nettype wire

/* rx_address_and_wake_filter.sv */
// Receive destination-address filter and wake frame detector with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rx_address_and_wake_filter (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxValid,
  input  wire logic        rxStart,
  input  wire logic        rxEnd,
  input  wire logic [7:0]  rxData,
  input  wire logic        lightSleep,
  output logic             acceptValid,
  output logic             frameAccept,
  output logic             addrMulticast,
  output logic             normalRxEnable,
  output logic             wakeIrq,
  output logic             powerEventOut
);
  // Register file
  logic [4:0]  mode_q;
  logic [31:0] staLo_q;
  logic [15:0] staHi_q;
  logic [31:0] hashLo_q;
  logic [31:0] hashHi_q;
  logic [3:0]  wakeCsr_q;
  logic [31:0] portMem_q [0:filter_pkg::PORT_WORDS-1];
  logic [2:0]  portPtr_q;

  // Bus slave state
  logic        awReady_q;
  logic        wReady_q;
  logic        bValid_q;
  logic [1:0]  bResp_q;
  logic        arReady_q;
  logic        rValid_q;
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;

  // Receive state
  filter_pkg::rx_phase_type phase_q;
  logic [10:0] byteIdx_q;
  logic [47:0] da_q;
  logic [31:0] hashCrc_q;
  logic        daDone_q;
  logic        acceptValid_q;
  logic        frameAccept_q;
  logic        mcast_q;
  logic        addrPass_q;
  logic        normalRx_q;
  logic        wakeIrq_q;
  logic        powerEvent_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Mode and wake controls
  wire mcPassAll  = mode_q[filter_pkg::MODE_MC_PASS];
  wire promisc    = mode_q[filter_pkg::MODE_PROMISC];
  wire inv        = mode_q[filter_pkg::MODE_INV];
  wire hashOnly   = mode_q[filter_pkg::MODE_HASH_ONLY];
  wire hpf        = mode_q[filter_pkg::MODE_HPF];
  wire wakeEn     = wakeCsr_q[filter_pkg::WK_EN];
  wire wakeRcv    = wakeCsr_q[filter_pkg::WK_RCV];
  wire wakeActive = wakeEn || lightSleep;

  // Bus write path
  wire        wrFire  = !awReady_q && !wReady_q && !bValid_q;
  wire [31:0] wrOld   = (awAddr_q == filter_pkg::OFF_MODE)    ? {27'h0, mode_q} :
                        (awAddr_q == filter_pkg::OFF_STA_LO)  ? staLo_q :
                        (awAddr_q == filter_pkg::OFF_STA_HI)  ? {16'h0, staHi_q} :
                        (awAddr_q == filter_pkg::OFF_HASH_LO) ? hashLo_q :
                        (awAddr_q == filter_pkg::OFF_HASH_HI) ? hashHi_q :
                        (awAddr_q == filter_pkg::OFF_WAKE_CSR) ? {28'h0, wakeCsr_q} :
                        32'h0;
  wire [31:0] wrVal   = merge(wrOld, wData_q, wStrb_q);
  wire        wrMode  = wrFire && (awAddr_q == filter_pkg::OFF_MODE);
  wire        wrStaLo = wrFire && (awAddr_q == filter_pkg::OFF_STA_LO);
  wire        wrStaHi = wrFire && (awAddr_q == filter_pkg::OFF_STA_HI);
  wire        wrHLo   = wrFire && (awAddr_q == filter_pkg::OFF_HASH_LO);
  wire        wrHHi   = wrFire && (awAddr_q == filter_pkg::OFF_HASH_HI);
  wire        wrWake  = wrFire && (awAddr_q == filter_pkg::OFF_WAKE_CSR);
  wire        wrPort  = wrFire && (awAddr_q == filter_pkg::OFF_WAKE_PORT);
  wire        wrOk    = wrMode || wrStaLo || wrStaHi || wrHLo || wrHHi || wrWake || wrPort
                        || (awAddr_q == filter_pkg::OFF_STATUS);
  wire [31:0] portVal = merge(portMem_q[portPtr_q], wData_q, wStrb_q);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awReady_q <= 1'b1;
      wReady_q  <= 1'b1;
      bValid_q  <= 1'b0;
      bResp_q   <= filter_pkg::RESP_OKAY;
      awAddr_q  <= 8'h00;
      wData_q   <= 32'h0;
      wStrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awReady_q) begin
        awReady_q <= 1'b0;
        awAddr_q  <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && wReady_q) begin
        wReady_q <= 1'b0;
        wData_q  <= s_axi_wdata;
        wStrb_q  <= s_axi_wstrb;
      end
      if (wrFire) begin
        bValid_q <= 1'b1;
        bResp_q  <= wrOk ? filter_pkg::RESP_OKAY : filter_pkg::RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q  <= 1'b0;
        awReady_q <= 1'b1;
        wReady_q  <= 1'b1;
      end
    end
  end

  // Registers written by software
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q   <= 5'h00;
      staLo_q  <= 32'h0;
      staHi_q  <= 16'h0;
      hashLo_q <= 32'h0;
      hashHi_q <= 32'h0;
    end else begin
      if (wrMode)  mode_q   <= wrVal[4:0];
      if (wrStaLo) staLo_q  <= wrVal;
      if (wrStaHi) staHi_q  <= wrVal[15:0];
      if (wrHLo)   hashLo_q <= wrVal;
      if (wrHHi)   hashHi_q <= wrVal;
    end
  end

  // Filter port: writes land in order and the pointer wraps after eight
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      portPtr_q <= 3'h0;
      for (int i = 0; i < filter_pkg::PORT_WORDS; i++) begin
        portMem_q[i] <= 32'h0;
      end
    end else if (wrPort) begin
      portMem_q[portPtr_q] <= (portPtr_q < 3'h4) ? {1'b0, portVal[30:0]} : portVal;
      portPtr_q            <= portPtr_q + 3'h1;
    end
  end

  // Bus read path
  logic [31:0] rdVal;
  logic        rdOk;
  always_comb begin
    rdOk  = 1'b1;
    rdVal = 32'h0;
    if (s_axi_araddr[7:2] == filter_pkg::OFF_MODE[7:2]) begin
      rdVal = {27'h0, mode_q};
    end else if (s_axi_araddr[7:2] == filter_pkg::OFF_STA_LO[7:2]) begin
      rdVal = staLo_q;
    end else if (s_axi_araddr[7:2] == filter_pkg::OFF_STA_HI[7:2]) begin
      rdVal = {16'h0, staHi_q};
    end else if (s_axi_araddr[7:2] == filter_pkg::OFF_HASH_LO[7:2]) begin
      rdVal = hashLo_q;
    end else if (s_axi_araddr[7:2] == filter_pkg::OFF_HASH_HI[7:2]) begin
      rdVal = hashHi_q;
    end else if (s_axi_araddr[7:2] == filter_pkg::OFF_WAKE_CSR[7:2]) begin
      rdVal = {27'h0, lightSleep, wakeCsr_q};
    end else if (s_axi_araddr[7:2] == filter_pkg::OFF_WAKE_PORT[7:2]) begin
      rdVal = portMem_q[portPtr_q];
    end else if (s_axi_araddr[7:2] == filter_pkg::OFF_STATUS[7:2]) begin
      rdVal = {23'h0, portPtr_q, phase_q, addrPass_q, mcast_q, frameAccept_q};
    end else begin
      rdOk = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0;
      rResp_q   <= filter_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arReady_q) begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b1;
      rData_q   <= rdVal;
      rResp_q   <= rdOk ? filter_pkg::RESP_OKAY : filter_pkg::RESP_SLVERR;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q  <= 1'b0;
      arReady_q <= 1'b1;
    end
  end

  // Destination capture and hash CRC
  wire [10:0] curIdx  = rxStart ? 11'h000 : byteIdx_q;
  wire        inDa    = rxValid && (curIdx <= filter_pkg::DA_LAST);
  wire        daLast  = rxValid && (curIdx == filter_pkg::DA_LAST)
                        && (rxStart || phase_q == filter_pkg::PH_ADDR);
  wire [31:0] crcBase = rxStart ? filter_pkg::CRC32_INIT : hashCrc_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_q   <= filter_pkg::PH_IDLE;
      byteIdx_q <= 11'h000;
      da_q      <= 48'h0;
      hashCrc_q <= filter_pkg::CRC32_INIT;
      daDone_q  <= 1'b0;
    end else begin
      daDone_q <= daLast;
      if (rxValid && (rxStart || byteIdx_q != filter_pkg::IDX_MAX)) begin
        byteIdx_q <= curIdx + 11'h001;
      end
      if (inDa) begin
        da_q[8*curIdx[2:0] +: 8] <= rxData;
        hashCrc_q <= filter_pkg::crc32_byte(crcBase, rxData);
      end
      case (phase_q)
        filter_pkg::PH_IDLE: begin
          if (rxValid && rxStart) phase_q <= filter_pkg::PH_ADDR;
        end
        filter_pkg::PH_ADDR: begin
          if (daLast) phase_q <= filter_pkg::PH_BODY;
          else if (rxValid && rxEnd) phase_q <= filter_pkg::PH_IDLE;
        end
        filter_pkg::PH_BODY: begin
          if (rxValid && rxEnd) phase_q <= filter_pkg::PH_IDLE;
        end
        default: phase_q <= filter_pkg::PH_IDLE;
      endcase
      if (rxValid && rxStart && !daLast) phase_q <= filter_pkg::PH_ADDR;
    end
  end

  // Address decision
  wire        isMcast    = da_q[0];
  wire        perfectHit = (da_q == {staHi_q, staLo_q});
  wire [5:0]  hashIdx    = hashCrc_q[31:26];
  wire        hashHit    = hashIdx[5] ? hashHi_q[hashIdx[4:0]] : hashLo_q[hashIdx[4:0]];
  wire        physHit    = (hashOnly && hpf) ? hashHit : perfectHit;
  wire        mcastHit   = hpf ? hashHit : perfectHit;
  wire        passAddr   = promisc ? 1'b1 :
                           (isMcast && mcPassAll) ? 1'b1 :
                           inv  ? !perfectHit :
                           isMcast ? mcastHit : physHit;

  // Wake filters
  filter_pkg::filter_cfg_type cfg [0:filter_pkg::NUM_FILTERS-1];
  logic [15:0] crcNow [0:filter_pkg::NUM_FILTERS-1];
  logic [filter_pkg::NUM_FILTERS-1:0] fHit;

  for (genvar f = 0; f < filter_pkg::NUM_FILTERS; f++) begin : g_filt
    assign cfg[f].mask   = portMem_q[f][30:0];
    assign cfg[f].cmd    = portMem_q[4][8*f +: 4];
    assign cfg[f].offset = portMem_q[5][8*f +: 8];
    assign cfg[f].crcRef = portMem_q[6 + f/2][16*(f%2) +: 16];
    assign fHit[f] = cfg[f].cmd[filter_pkg::CMD_EN]
                     && (cfg[f].cmd[filter_pkg::CMD_MCAST] == mcast_q)
                     && (crcNow[f] == cfg[f].crcRef);
    wake_crc_unit u_crc (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .byteValid  (rxValid),
      .frameStart (rxStart),
      .byteIdx    (curIdx),
      .byteData   (rxData),
      .cfg        (cfg[f]),
      .crcNow     (crcNow[f])
    );
  end

  wire wakeHit = wakeActive && rxValid && rxEnd && !rxStart
                 && (phase_q == filter_pkg::PH_BODY) && addrPass_q && (|fHit);
  wire wakeClr = wrWake && wData_q[filter_pkg::WK_RCV] && wStrb_q[0];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      acceptValid_q <= 1'b0;
      frameAccept_q <= 1'b0;
      mcast_q       <= 1'b0;
      addrPass_q    <= 1'b0;
      normalRx_q    <= 1'b1;
      wakeCsr_q     <= 4'h0;
      wakeIrq_q     <= 1'b0;
      powerEvent_q  <= 1'b0;
    end else begin
      acceptValid_q <= daDone_q;
      normalRx_q    <= !wakeActive;
      if (daDone_q) begin
        frameAccept_q <= passAddr && !wakeActive;
        mcast_q       <= isMcast;
        addrPass_q    <= passAddr;
      end
      if (wrWake) begin
        wakeCsr_q[filter_pkg::WK_EN]    <= wrVal[filter_pkg::WK_EN];
        wakeCsr_q[filter_pkg::WK_IRQEN] <= wrVal[filter_pkg::WK_IRQEN];
        wakeCsr_q[filter_pkg::WK_PMEEN] <= wrVal[filter_pkg::WK_PMEEN];
      end
      // Detection wins over a clear in the same cycle
      if (wakeHit) wakeCsr_q[filter_pkg::WK_RCV] <= 1'b1;
      else if (wakeClr) wakeCsr_q[filter_pkg::WK_RCV] <= 1'b0;
      wakeIrq_q    <= wakeRcv && wakeCsr_q[filter_pkg::WK_IRQEN];
      powerEvent_q <= wakeRcv && wakeCsr_q[filter_pkg::WK_PMEEN];
    end
  end

  assign s_axi_awready  = awReady_q;
  assign s_axi_wready   = wReady_q;
  assign s_axi_bvalid   = bValid_q;
  assign s_axi_bresp    = bResp_q;
  assign s_axi_arready  = arReady_q;
  assign s_axi_rvalid   = rValid_q;
  assign s_axi_rdata    = rData_q;
  assign s_axi_rresp    = rResp_q;
  assign acceptValid    = acceptValid_q;
  assign frameAccept    = frameAccept_q;
  assign addrMulticast  = mcast_q;
  assign normalRxEnable = normalRx_q;
  assign wakeIrq        = wakeIrq_q;
  assign powerEventOut  = powerEvent_q;

  // Checks
  chk_da_decision: assert property (@(posedge clk_sys) disable iff (!reset_n)
    daLast |-> ##2 acceptValid_q) else $error("decision not two cycles after last address byte");
  chk_perfect_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
    daDone_q && mode_q == 5'h00 && !wakeActive |=> frameAccept_q == $past(perfectHit))
    else $error("perfect mode decision wrong");
  chk_hash_perfect: assert property (@(posedge clk_sys) disable iff (!reset_n)
    daDone_q && mode_q == 5'h01 && isMcast && !wakeActive |=> frameAccept_q == $past(hashHit))
    else $error("hash-perfect multicast decision wrong");
  chk_hash_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
    daDone_q && mode_q == 5'h03 && !wakeActive |=> frameAccept_q == $past(hashHit))
    else $error("hash-only decision wrong");
  chk_inverse_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
    daDone_q && mode_q == 5'h04 && !wakeActive |=> frameAccept_q != $past(perfectHit))
    else $error("inverse decision wrong");
  chk_promisc_all: assert property (@(posedge clk_sys) disable iff (!reset_n)
    daDone_q && promisc && !wakeActive |=> acceptValid_q && frameAccept_q)
    else $error("promiscuous frame rejected");
  chk_mcast_pass: assert property (@(posedge clk_sys) disable iff (!reset_n)
    daDone_q && mcPassAll && isMcast && !wakeActive |=> frameAccept_q)
    else $error("multicast not passed");
  chk_wake_blocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    daDone_q && wakeActive |=> !frameAccept_q && !normalRx_q)
    else $error("frame received while wake detection active");
  chk_wake_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wakeHit && wakeCsr_q[filter_pkg::WK_PMEEN] |=> wakeRcv ##1 powerEvent_q)
    else $error("wake detection not flagged");
  chk_sleep_forced: assert property (@(posedge clk_sys) disable iff (!reset_n)
    lightSleep && !wakeEn |=> !normalRx_q) else $error("light sleep left wake detection off");
endmodule
`default_nettype wire

/* rx_source.sv */
// Receive byte source model standing in for the MAC receive path
`timescale 1ns/1ps
`default_nettype none
module rx_source (
  input  wire logic       clk_sys,
  output logic            rxValid,
  output logic            rxStart,
  output logic            rxEnd,
  output logic      [7:0] rxData
);
  initial begin
    rxValid = 1'b0;
    rxStart = 1'b0;
    rxEnd   = 1'b0;
    rxData  = 8'h00;
  end
  // Destination low byte first, body byte i is i^3c; idle data toggles
  task automatic send(input logic [47:0] da, input int len, input int gap);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_sys);
      rxValid <= 1'b1;
      rxStart <= (i == 0);
      rxEnd   <= (i == len - 1);
      rxData  <= (i < 6) ? da[8*i+:8] : (8'(i) ^ 8'h3c);
      for (int g = 0; g < gap; g++) begin
        @(posedge clk_sys);
        rxValid <= 1'b0;
        rxStart <= 1'b0;
        rxData  <= ~rxData;
      end
    end
    @(posedge clk_sys);
    rxValid <= 1'b0;
    rxEnd   <= 1'b0;
    rxData  <= ~rxData;
  endtask
endmodule
`default_nettype wire

/* rx_address_and_wake_filter_tb.sv */
// Self-checking bench for the receive address and wake filter
`timescale 1ns/1ps
`default_nettype none
module rx_address_and_wake_filter_tb;
  logic clk_sys, reset_n, awv, wv, bre, arv, rre, lightSleep, seen, gotAcc;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, seed, wm, c;
  logic [1:0] resp;
  logic [3:0] ws;
  logic [47:0] sta, da;
  logic [63:0] hash;
  logic [31:0] w [8];
  logic [4:0] modes [9] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h1b, 5'h10, 5'h13, 5'h11, 5'h14};
  int n_errors, compares, cycles;
  wire awr, wr_, bv, arr, rv, accV, accF, mcast, normEn, irq, power_event_output, rxV, rxS, rxE;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [7:0] rxD;
  rx_source src (.clk_sys(clk_sys), .rxValid(rxV), .rxStart(rxS), .rxEnd(rxE), .rxData(rxD));
  rx_address_and_wake_filter dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .rxValid(rxV), .rxStart(rxS), .rxEnd(rxE), .rxData(rxD),
    .lightSleep(lightSleep), .acceptValid(accV), .frameAccept(accF),
    .addrMulticast(mcast), .normalRxEnable(normEn), .wakeIrq(irq), .powerEventOut(power_event_output));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
    if (accV === 1'b1) begin
      seen <= 1'b1;
      gotAcc <= accF;
    end
  end
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
    bre <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rd = rdat;
    resp = rr;
    rre <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] crcb(input logic [31:0] x, input logic [31:0] p,
                                       input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ p) : (x >> 1);
    return x;
  endfunction
  // Reference decision of the address filter
  function automatic logic expAcc(input logic [4:0] m, input logic [47:0] d);
    logic [31:0] h;
    h = 32'hffffffff;
    for (int i = 0; i < 6; i++)
      h = crcb(h, 32'hedb88320, d[8*i+:8]);
    if (m[3]) return 1'b1;
    if (m[4] && d[0]) return 1'b1;
    if (m[2]) return d != sta;
    if (m[0] && (m[1] || d[0])) return hash[h[31:26]];
    return d == sta;
  endfunction
  task automatic frame(input logic [4:0] m, input logic [47:0] d);
    seen = 1'b0;
    src.send(d, 20, {$random(seed)} % 3);
    repeat (3) @(posedge clk_sys);
    check(seen, 1);
    check(mcast, d[0]);
    check(gotAcc, expAcc(m, d));
  endtask
  initial begin
    {reset_n, awv, wv, bre, arv, rre, lightSleep, awa, ara, wd} = '0;
    seed = 32'hcf38bd61;
    ws = 4'hf;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    sta = 48'({$random(seed), $random(seed)});
    sta[0] = 1'b0;
    hash = {$random(seed), $random(seed)};
    wr(8'h04, sta[31:0]);
    wr(8'h08, {16'h0000, sta[47:32]});
    wr(8'h0c, hash[31:0]);
    wr(8'h10, hash[63:32]);
    rdr(8'h08);
    check(rd, {16'h0000, sta[47:32]});
    // Upper lanes only: lower half of the station word must survive
    ws <= 4'hc;
    wr(8'h04, ~sta[31:0]);
    ws <= 4'hf;
    rdr(8'h04);
    check(rd, {~sta[31:16], sta[15:0]});
    wr(8'h04, sta[31:0]);
    rdr(8'h20);
    check(resp, 2'h2);
    wr(8'h24, 32'h0);
    check(resp, 2'h2);
    foreach (modes[i]) begin
      wr(8'h00, {27'h0, modes[i]});
      for (int k = 0; k < 7; k++) begin
        da = 48'({$random(seed), $random(seed)});
        if (k == 0) da = sta;
        if (k == 1) da = sta ^ 48'h800000000000;
        if (k == 2) da = '1;
        if (k == 3) da[0] = 1'b0;
        frame(modes[i], da);
      end
      $display("mode %h done", modes[i]);
    end
    wr(8'h00, 32'h0);
    wm = $random(seed) & 32'h7fffffff;
    c = 32'h0000ffff;
    for (int j = 0; j < 31; j++)
      if (wm[j]) c = crcb(c, 32'h0000a001, 8'(14 + j) ^ 8'h3c);
    w = '{wm, 0, 0, 0, 32'h1, 32'h0e0e0e0e, {16'h0, c[15:0]}, 0};
    foreach (w[i]) wr(8'h18, w[i]);
    wr(8'h14, 32'hd);
    repeat (2) @(posedge clk_sys);
    check(normEn, 0);
    src.send(sta ^ 48'h10000, 46, 0);
    repeat (4) @(posedge clk_sys);
    check(irq, 0);
    src.send(sta, 46, 0);
    repeat (4) @(posedge clk_sys);
    check({irq, power_event_output}, 2'h3);
    check(gotAcc, 0);
    rdr(8'h14);
    check(rd[1], 1);
    wr(8'h14, 32'h2);
    lightSleep <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(normEn, 0);
    check({irq, power_event_output}, 2'h0);
    lightSleep <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(normEn, 1);
    $display("wake test done");
    give_verdict();
  end
endmodule
`default_nettype wire
